// ### rtl/motor_pwm_config_and_fault.sv
/*
 configuration and fault-protection part of a six-channel motor pwm unit:
 buffered reload-rate, prescaler and correction settings, write-once
 dead-time and disable mapping, fault inputs with event flags, and the
 dead-time and disable stage in front of the pwm pins.
 assumes the external counter pulses cycle_start once per pwm cycle and
 advances only on pwm_tick; fault pins and raw pwm are synchronous-safe
 levels (fault pins are still synchronised here).
*/
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
// Operation
// - new reload rate used after current load cycle
// - reload every 1, 2, 4 or 8 cycles
// - prescaler switches at load with permit set
// - prescaler divides bus clock by 1/2/4/8
// - reads return buffered fields
// - software correction bits sampled each cycle start; code samples only with sensing select 0 or 1
// - correction bit 1 selects even value register
// - complementary dead time equals register count plus one cycle
// - dead time counts undivided clock cycles
// - dead time and mapping write once
// - mapping selects outputs forced off
// - per-input automatic or manual recovery mode
// - per-input interrupt enable gates request
// - fault always disables mapped outputs
// - event flag set within three cycles
// - event flag held until acknowledged
// - status shows synchronised fault pin level
// - load permit write-only, cleared after transfer
// - reload flag set every reload cycle
// - acknowledge reads zero, one clears flag
module motor_pwm_config_and_fault
   import pwm_cfg_pkg::*;
(
   input wire logic ref_clk, // bus clock
   input wire logic reset, // synchronous, active high
   input wire logic [pwm_cfg_pkg::AW-1:0] reg_addr, // register index
   input wire logic [pwm_cfg_pkg::DW-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [pwm_cfg_pkg::DW-1:0] reg_rdata, // read data, next cycle
   input wire logic cycle_start, // pulse: pwm cycle begins
   input wire logic [pwm_cfg_pkg::NPWM-1:0] pwm_raw, // generator outputs
   input wire logic bank_disable, // software bank disable level
   input wire logic [pwm_cfg_pkg::NFLT-1:0] fault_pin, // fault inputs
   output logic pwm_tick, // counter advance enable
   output logic reload_pulse, // pulse: reload cycle starts
   output logic load_strobe, // pulse: buffered values transfer
   output logic generator_on, // generator enable
   output logic [pwm_cfg_pkg::NPAIR-1:0] value_sel, // 1 = even value reg
   output logic [pwm_cfg_pkg::NPWM-1:0] pwm_out, // pins after dead time
   output logic fault_irq_req // fault interrupt request level
);
   import pwm_cfg_pkg::*;

   logic [1:0] reload_rate_sel_reg;
   logic [2:0] pair_value_sel_reg;
   logic [1:0] pwm_clock_divider_reg;
   logic [1:0] rate_act_reg;
   logic [1:0] div_act_reg;
   logic [DW-1:0] dead_time_count_reg;
   logic [DW-1:0] output_disable_mapping_reg;
   logic dead_written_reg;
   logic dmap_written_reg;
   logic [NFLT-1:0] fault_auto_recover_reg;
   logic [NFLT-1:0] fault_irq_en_reg;
   logic [NFLT-1:0] fault_event_reg;
   logic [NFLT-1:0] sync1_reg;
   logic [NFLT-1:0] sync2_reg;
   logic [NFLT-1:0] sync3_reg;
   logic [NFLT-1:0] fault_rise;
   logic [NFLT-1:0] ack_hit;
   logic [NFLT-1:0] fault_active;
   logic generator_on_reg;
   logic load_permit_reg;
   logic reload_flag_reg;
   logic rflag_armed_reg;
   logic [1:0] current_sense_sel_reg;
   logic complementary_reg;
   logic [2:0] presc_cnt_reg;
   logic [3:0] cyc_cnt_reg;
   logic reload_now;
   logic pwm_tick_reg;
   logic reload_pulse_reg;
   logic load_strobe_reg;
   logic [NPAIR-1:0] value_sel_reg;
   logic [NPWM-1:0] dt_out;
   logic [NPWM-1:0] pwm_out_reg;
   logic force_off;
   logic wr_rate;
   logic wr_ctl1;
   logic [DW-1:0] rdata_next;
   logic [DW-1:0] rdata_reg;
   logic [DW-1:0] fctl_view;
   logic [DW-1:0] fsta_view;

   assign wr_rate = reg_wr && (reg_addr == OFS_RATE);
   assign wr_ctl1 = reg_wr && (reg_addr == OFS_CTL1);

   // buffered settings; software should set these before enabling
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reload_rate_sel_reg <= 2'h0;
         pair_value_sel_reg <= 3'h0;
         pwm_clock_divider_reg <= 2'h0;
      end else if (wr_rate) begin
         reload_rate_sel_reg <= reg_wdata[RATE_LSB +: 2];
         pair_value_sel_reg <= reg_wdata[SEL_LSB +: 3];
         pwm_clock_divider_reg <= reg_wdata[DIV_LSB +: 2];
      end
   end

   // control register 1
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         generator_on_reg <= 1'b0;
         current_sense_sel_reg <= 2'h0;
         complementary_reg <= 1'b0;
      end else if (wr_ctl1) begin
         generator_on_reg <= reg_wdata[GEN_BIT];
         current_sense_sel_reg <= reg_wdata[ISEL_LSB +: 2];
         complementary_reg <= reg_wdata[CMPL_BIT];
      end
   end

   // prescaler on the active divider code only
   always_ff @(posedge ref_clk) begin
      if (reset || !generator_on_reg) begin
         presc_cnt_reg <= 3'h0;
         pwm_tick_reg <= 1'b0;
      end else if (presc_cnt_reg >= DIV_LAST[div_act_reg]) begin
         presc_cnt_reg <= 3'h0;
         pwm_tick_reg <= 1'b1;
      end else begin
         presc_cnt_reg <= presc_cnt_reg + 3'h1;
         pwm_tick_reg <= 1'b0;
      end
   end

   // reload cycle counter: counts pwm cycles against the active rate
   assign reload_now = cycle_start && (cyc_cnt_reg >= RELOAD_PER[rate_act_reg]
                       - CNT_ONE);

   always_ff @(posedge ref_clk) begin
      if (reset || !generator_on_reg) begin
         cyc_cnt_reg <= 4'h0;
      end else if (reload_now) begin
         cyc_cnt_reg <= 4'h0;
      end else if (cycle_start) begin
         cyc_cnt_reg <= cyc_cnt_reg + CNT_ONE;
      end
   end

   // the rate only takes effect once the running load cycle ends
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rate_act_reg <= 2'h0;
      end else if (reload_now) begin
         rate_act_reg <= reload_rate_sel_reg;
      end
   end

   // prescaler waits for the permit and a reload boundary
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         div_act_reg <= 2'h0;
      end else if (reload_now && load_permit_reg) begin
         div_act_reg <= pwm_clock_divider_reg;
      end
   end

   // load permit: transfer clears it, a write in that same cycle re-arms it
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         load_permit_reg <= 1'b0;
      end else if (wr_ctl1 && reg_wdata[LOAD_BIT]) begin
         load_permit_reg <= 1'b1;
      end else if (reload_now) begin
         load_permit_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reload_pulse_reg <= 1'b0;
         load_strobe_reg <= 1'b0;
      end else begin
         reload_pulse_reg <= reload_now;
         load_strobe_reg <= reload_now && load_permit_reg;
      end
   end

   // reload flag: cleared by reading it set then writing 0; a new
   // reload wins over the clear and disarms the sequence
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reload_flag_reg <= 1'b0;
         rflag_armed_reg <= 1'b0;
      end else if (reload_now) begin
         reload_flag_reg <= 1'b1;
         rflag_armed_reg <= 1'b0;
      end else if (wr_ctl1 && rflag_armed_reg && !reg_wdata[RFLAG_BIT]) begin
         reload_flag_reg <= 1'b0;
         rflag_armed_reg <= 1'b0;
      end else if (reg_rd && reg_addr == OFS_CTL1 && reload_flag_reg) begin
         rflag_armed_reg <= 1'b1;
      end
   end

   // software correction latched at each cycle start while sensing select is 0 or 1
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         value_sel_reg <= 3'h0;
      end else if (cycle_start && current_sense_sel_reg <= ISEL_SW_HI) begin
         value_sel_reg <= pair_value_sel_reg;
      end
   end

   // write-once registers: only the first write after reset lands
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dead_time_count_reg <= RST_BYTE;
         dead_written_reg <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_DEAD && !dead_written_reg) begin
         dead_time_count_reg <= reg_wdata;
         dead_written_reg <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         output_disable_mapping_reg <= RST_BYTE;
         dmap_written_reg <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_DMAP && !dmap_written_reg) begin
         output_disable_mapping_reg <= reg_wdata;
         dmap_written_reg <= 1'b1;
      end
   end

   // fault control: mode and interrupt enable per input
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fault_auto_recover_reg <= 4'h0;
         fault_irq_en_reg <= 4'h0;
      end else if (reg_wr && reg_addr == OFS_FCTL) begin
         for (int i = 0; i < NFLT; i++) begin
            fault_auto_recover_reg[i] <= reg_wdata[2*i];
            fault_irq_en_reg[i] <= reg_wdata[2*i+1];
         end
      end
   end

   // two-stage synchroniser; edge taken from the second stage
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         sync3_reg <= 4'h0;
      end else begin
         sync1_reg <= fault_pin;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign fault_rise = sync2_reg & ~sync3_reg;
   assign ack_hit = (reg_wr && reg_addr == OFS_FACK) ? reg_wdata[NFLT-1:0] : 4'h0;

   // a rising edge in the acknowledge cycle keeps the flag set
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fault_event_reg <= 4'h0;
      end else begin
         fault_event_reg <= fault_rise | (fault_event_reg & ~ack_hit);
      end
   end

   // manual mode holds the disable until acknowledged, automatic
   // follows the synchronised pin level
   always_comb begin
      for (int i = 0; i < NFLT; i++) begin
         fault_active[i] = fault_auto_recover_reg[i] ? sync2_reg[i]
                           : (fault_event_reg[i] | sync2_reg[i]);
      end
   end

   assign force_off = (|fault_active) || bank_disable;
   assign fault_irq_req = |(fault_event_reg & fault_irq_en_reg);

   // dead-time stage per pair, counted on the undivided clock so the
   // prescaler never stretches it
   for (genvar p = 0; p < NPAIR; p++) begin : g_pair
      dt_state_t state_reg;
      logic [DW-1:0] cnt_reg;
      logic side_reg;
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            state_reg <= DT_IDLE;
            cnt_reg <= RST_BYTE;
            side_reg <= 1'b0;
         end else begin
            unique case (state_reg)
               DT_IDLE: begin
                  side_reg <= pwm_raw[2*p];
                  cnt_reg <= dead_time_count_reg;
                  state_reg <= DT_WAIT;
               end
               DT_WAIT: begin
                  if (side_reg != pwm_raw[2*p]) begin
                     side_reg <= pwm_raw[2*p];
                     cnt_reg <= dead_time_count_reg;
                  end else if (cnt_reg == RST_BYTE) begin
                     state_reg <= DT_DRIVE;
                  end else begin
                     cnt_reg <= cnt_reg - 8'h01;
                  end
               end
               DT_DRIVE: begin
                  if (side_reg != pwm_raw[2*p]) begin
                     side_reg <= pwm_raw[2*p];
                     cnt_reg <= dead_time_count_reg;
                     state_reg <= DT_WAIT;
                  end
               end
               default: state_reg <= DT_IDLE;
            endcase
         end
      end
      always_comb begin
         if (complementary_reg) begin
            dt_out[2*p] = (state_reg == DT_DRIVE) && side_reg;
            dt_out[2*p+1] = (state_reg == DT_DRIVE) && !side_reg;
         end else begin
            dt_out[2*p] = pwm_raw[2*p];
            dt_out[2*p+1] = pwm_raw[2*p+1];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pwm_out_reg <= 6'h00;
      end else if (!generator_on_reg) begin
         pwm_out_reg <= 6'h00;
      end else if (force_off) begin
         pwm_out_reg <= dt_out & ~output_disable_mapping_reg[NPWM-1:0];
      end else begin
         pwm_out_reg <= dt_out;
      end
   end

   // register read views
   always_comb begin
      fctl_view = RST_BYTE;
      fsta_view = RST_BYTE;
      for (int i = 0; i < NFLT; i++) begin
         fctl_view[2*i] = fault_auto_recover_reg[i];
         fctl_view[2*i+1] = fault_irq_en_reg[i];
         fsta_view[2*i+1] = fault_event_reg[i];
         fsta_view[2*i] = sync2_reg[i];
      end
   end

   always_comb begin
      rdata_next = RST_BYTE;
      unique case (reg_addr)
         OFS_RATE: begin
            rdata_next[RATE_LSB +: 2] = reload_rate_sel_reg;
            rdata_next[SEL_LSB +: 3] = pair_value_sel_reg;
            rdata_next[DIV_LSB +: 2] = pwm_clock_divider_reg;
         end
         OFS_DEAD: rdata_next = dead_time_count_reg;
         OFS_DMAP: rdata_next = output_disable_mapping_reg;
         OFS_FCTL: rdata_next = fctl_view;
         OFS_FSTA: rdata_next = fsta_view;
         OFS_CTL1: begin
            rdata_next[GEN_BIT] = generator_on_reg;
            rdata_next[RFLAG_BIT] = reload_flag_reg;
            rdata_next[ISEL_LSB +: 2] = current_sense_sel_reg;
            rdata_next[CMPL_BIT] = complementary_reg;
         end
         default: rdata_next = RST_BYTE; // acknowledge reads zero
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_reg <= RST_BYTE;
      end else if (reg_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= RST_BYTE;
      end
   end

   assign reg_rdata = rdata_reg;
   assign pwm_tick = pwm_tick_reg;
   assign reload_pulse = reload_pulse_reg;
   assign load_strobe = load_strobe_reg;
   assign generator_on = generator_on_reg;
   assign value_sel = value_sel_reg;
   assign pwm_out = pwm_out_reg;
endmodule

// ### rtl/pwm_cfg_pkg.sv
/*
 constants for the motor pwm configuration and fault block: register
 offsets, field positions, reset values and code tables.
 assumes a single 25 mhz bus clock and 8-bit register data.
*/
package pwm_cfg_pkg;
   localparam int DW = 8;
   localparam int AW = 3;
   localparam int NFLT = 4;
   localparam int NPAIR = 3;
   localparam int NPWM = 6;
   // register offsets (indices on the plain register port)
   localparam logic [AW-1:0] OFS_RATE = 3'h0;
   localparam logic [AW-1:0] OFS_DEAD = 3'h1;
   localparam logic [AW-1:0] OFS_DMAP = 3'h2;
   localparam logic [AW-1:0] OFS_FCTL = 3'h3;
   localparam logic [AW-1:0] OFS_FSTA = 3'h4;
   localparam logic [AW-1:0] OFS_FACK = 3'h5;
   localparam logic [AW-1:0] OFS_CTL1 = 3'h6;
   // rate/prescale/correction fields
   localparam int RATE_LSB = 6;
   localparam int SEL_LSB = 3;
   localparam int DIV_LSB = 0;
   // control register 1 fields
   localparam int GEN_BIT = 0;
   localparam int LOAD_BIT = 1;
   localparam int RFLAG_BIT = 4;
   localparam int ISEL_LSB = 5;
   localparam int CMPL_BIT = 7;
   // fault control: mode bit at 2i, irq enable at 2i+1
   // fault status: event at 2i+1, level at 2i
   localparam logic [DW-1:0] RST_BYTE = 8'h00;
   localparam logic [1:0] ISEL_SW_HI = 2'h1;
   localparam logic [3:0] CNT_ONE = 4'h1;
   // reload period in pwm cycles per reload-rate code
   localparam logic [3:0] RELOAD_PER [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
   // prescaler terminal count per divider code
   localparam logic [2:0] DIV_LAST [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
   typedef enum logic [1:0] {
      DT_IDLE = 2'b00,
      DT_WAIT = 2'b01,
      DT_DRIVE = 2'b10
   } dt_state_t;
endpackage

// ### tb/motor_pwm_config_and_fault_monitor.sv
/* port checker for the pwm configuration and fault block.
 assumes the pwm_cfg_pkg register map; bound to the top module below. */
`timescale 1ns/10ps
module motor_pwm_config_and_fault_monitor
   import pwm_cfg_pkg::*;
(
   input wire logic ref_clk, // bus clock
   input wire logic reset, // sync reset
   input wire logic [pwm_cfg_pkg::AW-1:0] reg_addr, // index
   input wire logic reg_rd, // read strobe
   input wire logic [pwm_cfg_pkg::DW-1:0] reg_rdata, // read data
   input wire logic cycle_start, // cycle pulse
   input wire logic [pwm_cfg_pkg::NFLT-1:0] fault_pin, // fault inputs
   input wire logic pwm_tick, // counter enable
   input wire logic reload_pulse, // reload pulse
   input wire logic load_strobe, // transfer pulse
   input wire logic generator_on, // enable
   input wire logic fault_irq_req // irq level
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic rd_fsta;
   assign rd_fsta = reg_rd && reg_addr == OFS_FSTA;

   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   chk_load_reload: assert property (load_strobe |-> reload_pulse)
      else $error("transfer without reload");
   chk_reload_cause: assert property (reload_pulse |-> $past(cycle_start))
      else $error("reload without cycle start");
   chk_tick_gated: assert property (!generator_on && !$past(generator_on) |-> !pwm_tick)
      else $error("tick while generator off");
   chk_permit_zero: assert property (reg_rd && reg_addr == OFS_CTL1 |=>
      !reg_rdata[LOAD_BIT])
      else $error("load permit read as one");
   chk_pin_level: assert property ($stable(fault_pin) [*4] ##0 rd_fsta |=>
      {reg_rdata[6], reg_rdata[4], reg_rdata[2], reg_rdata[0]} == $past(fault_pin))
      else $error("status level differs from pin");
   chk_irq_flag: assert property (rd_fsta && fault_irq_req |=> (reg_rdata & 8'hAA) != 8'h00)
      else $error("irq without event flag");
   chk_flag_latency: assert property ($rose(fault_pin[0]) ##3 rd_fsta |=> reg_rdata[1])
      else $error("event flag late");
endmodule

bind motor_pwm_config_and_fault motor_pwm_config_and_fault_monitor mon (
   .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .cycle_start(cycle_start), .fault_pin(fault_pin),
   .pwm_tick(pwm_tick), .reload_pulse(reload_pulse), .load_strobe(load_strobe),
   .generator_on(generator_on), .fault_irq_req(fault_irq_req)
);

// ### tb/power_stage_model.sv
/* fault detector side of the motor power stage.
 assumes the bench commands each trip condition as a level. */
`timescale 1ns/10ps
module power_stage_model (
   input wire logic ref_clk, // bus clock
   input wire logic [3:0] trip, // commanded overload conditions
   output logic [3:0] fault_pin // detector outputs, active high
);
   initial fault_pin = 4'h0;
   // comparators are latched, so a trip reaches the pin one clock late
   always @(posedge ref_clk) begin
      fault_pin <= trip;
   end
endmodule

// ### tb/test_motor_pwm_config_and_fault.sv
/* self-checking bench for the pwm configuration and fault block.
 assumes the pwm_cfg_pkg register map and a 25 mhz bus clock. */
`timescale 1ns/10ps
module test_motor_pwm_config_and_fault;
   import pwm_cfg_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic cycle_start = 1'b0, bank_disable = 1'b0;
   logic [AW-1:0] reg_addr = 3'h0;
   logic [DW-1:0] reg_wdata = 8'h00;
   logic [NPWM-1:0] pwm_raw = 6'h00;
   logic [NFLT-1:0] trip = 4'h0;
   logic [NFLT-1:0] fault_pin;
   logic [DW-1:0] reg_rdata;
   logic pwm_tick, reload_pulse, load_strobe, generator_on, fault_irq_req;
   logic [NPAIR-1:0] value_sel;
   logic [NPWM-1:0] pwm_out;
   int n_tick = 0, n_rel = 0, n_load = 0, cycles = 0;
   int miscompares = 0, num_checks = 0;

   always #20 ref_clk = ~ref_clk;

   motor_pwm_config_and_fault uut (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cycle_start(cycle_start),
      .pwm_raw(pwm_raw), .bank_disable(bank_disable), .fault_pin(fault_pin),
      .pwm_tick(pwm_tick), .reload_pulse(reload_pulse), .load_strobe(load_strobe),
      .generator_on(generator_on), .value_sel(value_sel), .pwm_out(pwm_out),
      .fault_irq_req(fault_irq_req)
   );
   power_stage_model stage (.ref_clk(ref_clk), .trip(trip), .fault_pin(fault_pin));

   // non-blocking, so tasks snapshot the counts without racing this block
   always @(posedge ref_clk) begin
      n_tick <= n_tick + int'(pwm_tick);
      n_rel <= n_rel + int'(reload_pulse);
      n_load <= n_load + int'(load_strobe);
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp_v);
      num_checks++;
      if (got !== exp_v) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp_v);
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask

   // outputs read right after an edge still hold the settled previous cycle
   task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [7:0] m = 8'hFF);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      chk(reg_rdata & m, e);
   endtask

   task automatic cyc;
      cycle_start <= 1'b1;
      @(posedge ref_clk);
      cycle_start <= 1'b0;
      repeat (15) @(posedge ref_clk);
   endtask

   task automatic t_regs;
      for (int a = 0; a < 8; a++) rc(3'(a), 8'h00);
      wr(OFS_DEAD, 8'h12);
      wr(OFS_DEAD, 8'h34);
      rc(OFS_DEAD, 8'h12);
      wr(OFS_DMAP, 8'h15);
      wr(OFS_DMAP, 8'h2A);
      rc(OFS_DMAP, 8'h15);
      wr(OFS_FSTA, 8'hFF);
      rc(OFS_FSTA, 8'h00);
      wr(OFS_RATE, 8'hFB);
      rc(OFS_RATE, 8'hFB);
      wr(OFS_CTL1, 8'h02);
      rc(OFS_CTL1, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_rates;
      int t0, r0, l0;
      for (int c = 0; c < 4; c++) begin
         wr(OFS_RATE, 8'(c * 65));
         wr(OFS_CTL1, 8'h03);
         chk(8'(generator_on), 8'h01);
         l0 = n_load;
         repeat (8) cyc();
         chk(8'(n_load - l0), 8'h01);
         t0 = n_tick;
         r0 = n_rel;
         l0 = n_load;
         repeat (8) cyc();
         chk(8'(n_tick - t0), 8'(128 >> c));
         chk(8'(n_rel - r0), 8'(8 >> c));
         chk(8'(n_load - l0), 8'h00);
         rc(OFS_CTL1, 8'h11, 8'h13);
      end
      wr(OFS_RATE, 8'h00);
      wr(OFS_CTL1, 8'h01);
      repeat (8) cyc();
      t0 = n_tick;
      repeat (8) cyc();
      chk(8'(n_tick - t0), 8'h10);
      $display("test rates done");
   endtask

   task automatic t_value_sel;
      wr(OFS_CTL1, 8'h21);
      wr(OFS_RATE, 8'h28);
      chk(8'(value_sel), 8'h00);
      cyc();
      chk(8'(value_sel), 8'h05);
      wr(OFS_RATE, 8'h10);
      cyc();
      chk(8'(value_sel), 8'h02);
      // sensing selection: buffered bits must not be sampled
      wr(OFS_CTL1, 8'h41);
      wr(OFS_RATE, 8'h28);
      cyc();
      chk(8'(value_sel), 8'h02);
      $display("test value_sel done");
   endtask

   task automatic t_dead_time;
      int n = 0;
      wr(OFS_CTL1, 8'h81);
      pwm_raw <= 6'h01;
      repeat (40) @(posedge ref_clk);
      chk(8'(pwm_out[1:0]), 8'h01);
      pwm_raw <= 6'h00;
      repeat (60) begin
         @(posedge ref_clk);
         if (pwm_out[1:0] === 2'b00) n++;
      end
      chk(8'(n), 8'h13);
      chk(8'(pwm_out[1:0]), 8'h02);
      $display("test dead_time done");
   endtask

   task automatic t_faults;
      wr(OFS_CTL1, 8'h01);
      pwm_raw <= 6'h3F;
      wr(OFS_FCTL, 8'h02);
      repeat (40) @(posedge ref_clk);
      chk(8'(pwm_out), 8'h3F);
      trip <= 4'h1;
      repeat (4) @(posedge ref_clk);
      rc(OFS_FSTA, 8'h03);
      chk(8'(fault_irq_req), 8'h01);
      chk(8'(pwm_out), 8'h2A);
      trip <= 4'h0;
      repeat (8) @(posedge ref_clk);
      chk(8'(pwm_out), 8'h2A);
      wr(OFS_FACK, 8'h00);
      rc(OFS_FSTA, 8'h02);
      rc(OFS_FACK, 8'h00);
      wr(OFS_FACK, 8'h01);
      rc(OFS_FSTA, 8'h00);
      cyc();
      chk(8'(pwm_out), 8'h3F);
      chk(8'(fault_irq_req), 8'h00);
      wr(OFS_FCTL, 8'h04);
      trip <= 4'h2;
      repeat (4) @(posedge ref_clk);
      rc(OFS_FSTA, 8'h0C);
      chk(8'(fault_irq_req), 8'h00);
      chk(8'(pwm_out), 8'h2A);
      trip <= 4'h0;
      cyc();
      chk(8'(pwm_out), 8'h3F);
      rc(OFS_FSTA, 8'h08);
      wr(OFS_FACK, 8'h02);
      bank_disable <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(8'(pwm_out), 8'h2A);
      bank_disable <= 1'b0;
      $display("test faults done");
   endtask

   // a second reset must reopen the write-once latches
   task automatic t_rearm;
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      wr(OFS_DEAD, 8'h34);
      rc(OFS_DEAD, 8'h34);
      chk(8'(generator_on), 8'h00);
      $display("test rearm done");
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs();
      t_rates();
      t_value_sel();
      t_dead_time();
      t_faults();
      t_rearm();
      give_verdict();
   end
endmodule
